// file: design/tlc_top.v
`timescale 1ns/10ps
`default_nettype none
`include "tlc_defs.vh"

// Summary of operation
// RULE_01 - Internal result above internal upper limit sets internal status bit 2.
// RULE_02 - Internal result below internal lower limit sets internal status bit 1.
// RULE_03 - Remote one result above its upper limit sets its status bit 2.
// RULE_04 - Remote one result below its lower limit sets its status bit 1.
// RULE_05 - Remote two result above its upper limit sets its status bit 2.
// RULE_06 - Remote two result below its lower limit sets its status bit 1.
// RULE_07 - Limits are 12-bit two's complement, 0.125 C per unit, compared signed.
// RULE_08 - All six limit registers are writable and read back the last value.
// RULE_09 - Each channel has its own enable bit; zero means disabled.
// RULE_10 - Per-channel two-bit field selects averaging of 4, 8, 16 or 32 samples.
// RULE_11 - Comparisons run only when enabled, once per new averaged result.
module tlc_top #(
  parameter LW = `TLC_LIM_W,
  parameter NC = `TLC_NUM_CH
) (
  input  wire                   clk_sys,
  input  wire                   rstn,
  input  wire [`TLC_ADDR_W-1:0] reg_addr,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire [`TLC_DATA_W-1:0] reg_wdata,
  output reg  [`TLC_DATA_W-1:0] reg_rdata_r,
  output reg                    reg_rvalid_r,
  input  wire [NC-1:0]          smp_valid,
  input  wire [NC*LW-1:0]       smp_data,
  output reg  [NC-1:0]          alarm_hi_r,
  output reg  [NC-1:0]          alarm_lo_r
);

  reg  [NC-1:0]             enables_r;
  reg  [`TLC_AVG_ALL_W-1:0] avg_cfg_r;
  reg  [NC*LW-1:0]          lim_hi_r;
  reg  [NC*LW-1:0]          lim_lo_r;
  reg  [NC*LW-1:0]          res_hold_r;
  wire [NC-1:0]             res_vld;
  wire [NC*LW-1:0]          res_bus;
  wire [NC-1:0]             hi_hit;
  wire [NC-1:0]             lo_hit;
  wire [NC-1:0]             stat_clr;
  reg  [`TLC_DATA_W-1:0]    rdata_nxt;
  integer                   i;

  // Per-channel averaging and limit checking
  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1)
    begin : g_ch
      tlc_avg #(
        .DW (LW),
        .AW (LW + 5)
      ) u_avg (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .enable      (enables_r[g]),                                    // [RULE_09]
        .avg_sel     (avg_cfg_r[g*`TLC_AVG_FLD_W +: `TLC_AVG_FLD_W]),  // [RULE_10]
        .smp_valid   (smp_valid[g]),
        .smp_data    (smp_data[g*LW +: LW]),
        .res_valid_r (res_vld[g]),
        .res_data_r  (res_bus[g*LW +: LW])
      );
      tlc_cmp #(
        .DW (LW)
      ) u_cmp (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .enable    (enables_r[g]),                                      // [RULE_11]
        .res_valid (res_vld[g]),
        .res_data  (res_bus[g*LW +: LW]),
        .lim_hi    (lim_hi_r[g*LW +: LW]),
        .lim_lo    (lim_lo_r[g*LW +: LW]),
        .hi_hit_r  (hi_hit[g]),
        .lo_hit_r  (lo_hit[g])
      );
    end
  endgenerate

  // Reading a status register clears its flags
  assign stat_clr[0] = reg_rd && (reg_addr == `TLC_REG_STAT_INT);
  assign stat_clr[1] = reg_rd && (reg_addr == `TLC_REG_STAT_R1);
  assign stat_clr[2] = reg_rd && (reg_addr == `TLC_REG_STAT_R2);

  // Sticky alarm flags, a new hit beats a clear in the same cycle
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      alarm_hi_r <= {NC{1'b0}};
      alarm_lo_r <= {NC{1'b0}};
    end
    else
    begin
      alarm_hi_r <= hi_hit | (alarm_hi_r & ~stat_clr); // [RULE_01] [RULE_03] [RULE_05]
      alarm_lo_r <= lo_hit | (alarm_lo_r & ~stat_clr); // [RULE_02] [RULE_04] [RULE_06]
    end
  end

  // Last averaged result per channel for readback
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      res_hold_r <= {(NC*LW){1'b0}};
    end
    else
    begin
      for (i = 0; i < NC; i = i + 1)
      begin
        if (res_vld[i])
        begin
          res_hold_r[i*LW +: LW] <= res_bus[i*LW +: LW];
        end
      end
    end
  end

  // Host writes to control and limit registers
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      enables_r <= `TLC_EN_RST;
      avg_cfg_r <= `TLC_AVG_RST;
      lim_hi_r  <= {NC{`TLC_HI_RST}};
      lim_lo_r  <= {NC{`TLC_LO_RST}};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `TLC_REG_ENABLES: enables_r        <= reg_wdata[NC-1:0];              // [RULE_09]
        `TLC_REG_AVG:     avg_cfg_r        <= reg_wdata[`TLC_AVG_ALL_W-1:0];  // [RULE_10]
        `TLC_REG_INT_HI:  lim_hi_r[0*LW +: LW] <= reg_wdata[LW-1:0];          // [RULE_08]
        `TLC_REG_INT_LO:  lim_lo_r[0*LW +: LW] <= reg_wdata[LW-1:0];          // [RULE_08]
        `TLC_REG_R1_HI:   lim_hi_r[1*LW +: LW] <= reg_wdata[LW-1:0];          // [RULE_08]
        `TLC_REG_R1_LO:   lim_lo_r[1*LW +: LW] <= reg_wdata[LW-1:0];          // [RULE_08]
        `TLC_REG_R2_HI:   lim_hi_r[2*LW +: LW] <= reg_wdata[LW-1:0];          // [RULE_08]
        `TLC_REG_R2_LO:   lim_lo_r[2*LW +: LW] <= reg_wdata[LW-1:0];          // [RULE_08]
        default:          enables_r        <= enables_r;
      endcase
    end
  end

  // Read data select, unmapped offsets read zero
  always @*
  begin
    rdata_nxt = `TLC_RDATA_RST;
    case (reg_addr)
      `TLC_REG_ENABLES:  rdata_nxt[NC-1:0] = enables_r;
      `TLC_REG_AVG:      rdata_nxt[`TLC_AVG_ALL_W-1:0] = avg_cfg_r;
      `TLC_REG_STAT_INT:
      begin
        rdata_nxt[`TLC_STAT_HI_BIT] = alarm_hi_r[0];
        rdata_nxt[`TLC_STAT_LO_BIT] = alarm_lo_r[0];
      end
      `TLC_REG_STAT_R1:
      begin
        rdata_nxt[`TLC_STAT_HI_BIT] = alarm_hi_r[1];
        rdata_nxt[`TLC_STAT_LO_BIT] = alarm_lo_r[1];
      end
      `TLC_REG_STAT_R2:
      begin
        rdata_nxt[`TLC_STAT_HI_BIT] = alarm_hi_r[2];
        rdata_nxt[`TLC_STAT_LO_BIT] = alarm_lo_r[2];
      end
      `TLC_REG_INT_HI:   rdata_nxt[LW-1:0] = lim_hi_r[0*LW +: LW];   // [RULE_08]
      `TLC_REG_INT_LO:   rdata_nxt[LW-1:0] = lim_lo_r[0*LW +: LW];   // [RULE_08]
      `TLC_REG_R1_HI:    rdata_nxt[LW-1:0] = lim_hi_r[1*LW +: LW];   // [RULE_08]
      `TLC_REG_R1_LO:    rdata_nxt[LW-1:0] = lim_lo_r[1*LW +: LW];   // [RULE_08]
      `TLC_REG_R2_HI:    rdata_nxt[LW-1:0] = lim_hi_r[2*LW +: LW];   // [RULE_08]
      `TLC_REG_R2_LO:    rdata_nxt[LW-1:0] = lim_lo_r[2*LW +: LW];   // [RULE_08]
      `TLC_REG_RES_INT:  rdata_nxt[LW-1:0] = res_hold_r[0*LW +: LW];
      `TLC_REG_RES_R1:   rdata_nxt[LW-1:0] = res_hold_r[1*LW +: LW];
      `TLC_REG_RES_R2:   rdata_nxt[LW-1:0] = res_hold_r[2*LW +: LW];
      default:           rdata_nxt = `TLC_RDATA_RST;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata_r  <= `TLC_RDATA_RST;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

endmodule // tlc_top
`default_nettype wire

// file: design/tlc_defs.vh
`ifndef TLC_DEFS_VH
`define TLC_DEFS_VH

// Register port widths
`define TLC_ADDR_W          8
`define TLC_DATA_W          16
`define TLC_LIM_W           12
`define TLC_NUM_CH          3

// Register offsets
`define TLC_REG_ENABLES     8'h00
`define TLC_REG_AVG         8'h01
`define TLC_REG_STAT_INT    8'h02
`define TLC_REG_STAT_R1     8'h03
`define TLC_REG_STAT_R2     8'h04
`define TLC_REG_INT_HI      8'h05
`define TLC_REG_INT_LO      8'h06
`define TLC_REG_R1_HI       8'h07
`define TLC_REG_R1_LO       8'h08
`define TLC_REG_R2_HI       8'h09
`define TLC_REG_R2_LO       8'h0a
`define TLC_REG_RES_INT     8'h0b
`define TLC_REG_RES_R1      8'h0c
`define TLC_REG_RES_R2      8'h0d

// Field positions
`define TLC_STAT_HI_BIT     2
`define TLC_STAT_LO_BIT     1
`define TLC_AVG_FLD_W       2
`define TLC_AVG_ALL_W       6

// Reset values
`define TLC_HI_RST          12'h7ff
`define TLC_LO_RST          12'h800
`define TLC_EN_RST          3'h0
`define TLC_AVG_RST         6'h00
`define TLC_RDATA_RST       16'h0000

// Averaging: 4 samples at field value 0, doubling per step
`define TLC_AVG_SHIFT_BASE  3'h2
`define TLC_AVG_CNT_W       6

`endif

// file: design/tlc_avg.v
`timescale 1ns/10ps
`default_nettype none
`include "tlc_defs.vh"

module tlc_avg #(
  parameter DW = 12,
  parameter AW = 17
) (
  input  wire          clk_sys,
  input  wire          rstn,
  input  wire          enable,
  input  wire [1:0]    avg_sel,
  input  wire          smp_valid,
  input  wire [DW-1:0] smp_data,
  output reg           res_valid_r,
  output reg  [DW-1:0] res_data_r
);

  reg signed [AW-1:0]             acc_r;
  reg        [`TLC_AVG_CNT_W-1:0] cnt_r;
  wire       [2:0]                shift;
  wire       [`TLC_AVG_CNT_W-1:0] last_cnt;
  wire signed [AW-1:0]            sum;
  wire signed [AW-1:0]            mean;

  // Window length 4, 8, 16 or 32 from the select field
  assign shift    = {1'b0, avg_sel} + `TLC_AVG_SHIFT_BASE;
  assign last_cnt = ({{(`TLC_AVG_CNT_W-1){1'b0}}, 1'b1} << shift) - {{(`TLC_AVG_CNT_W-1){1'b0}}, 1'b1};
  assign sum      = acc_r + {{(AW-DW){smp_data[DW-1]}}, smp_data};
  assign mean     = sum >>> shift;

  // Accumulate, close the window, emit one result pulse
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_r       <= {AW{1'b0}};
      cnt_r       <= {`TLC_AVG_CNT_W{1'b0}};
      res_valid_r <= 1'b0;
      res_data_r  <= {DW{1'b0}};
    end
    else if (!enable)
    begin
      acc_r       <= {AW{1'b0}};              // [RULE_09]
      cnt_r       <= {`TLC_AVG_CNT_W{1'b0}};
      res_valid_r <= 1'b0;
    end
    else if (smp_valid)
    begin
      if (cnt_r >= last_cnt)                  // [RULE_10]
      begin
        res_data_r  <= mean[DW-1:0];
        res_valid_r <= 1'b1;
        acc_r       <= {AW{1'b0}};
        cnt_r       <= {`TLC_AVG_CNT_W{1'b0}};
      end
      else
      begin
        acc_r       <= sum;
        cnt_r       <= cnt_r + {{(`TLC_AVG_CNT_W-1){1'b0}}, 1'b1};
        res_valid_r <= 1'b0;
      end
    end
    else
    begin
      res_valid_r <= 1'b0;
    end
  end

endmodule // tlc_avg
`default_nettype wire

// file: design/tlc_cmp.v
`timescale 1ns/10ps
`default_nettype none
`include "tlc_defs.vh"

module tlc_cmp #(
  parameter DW = 12
) (
  input  wire          clk_sys,
  input  wire          rstn,
  input  wire          enable,
  input  wire          res_valid,
  input  wire [DW-1:0] res_data,
  input  wire [DW-1:0] lim_hi,
  input  wire [DW-1:0] lim_lo,
  output reg           hi_hit_r,
  output reg           lo_hit_r
);

  wire eval;

  // Only a fresh result of an enabled channel is judged
  assign eval = enable & res_valid;           // [RULE_11]

  // Signed compare against both limits
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      hi_hit_r <= 1'b0;
      lo_hit_r <= 1'b0;
    end
    else
    begin
      hi_hit_r <= eval & ($signed(res_data) > $signed(lim_hi)); // [RULE_07]
      lo_hit_r <= eval & ($signed(res_data) < $signed(lim_lo)); // [RULE_07]
    end
  end

endmodule // tlc_cmp
`default_nettype wire

// file: testbench/tlc_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlc_defs.vh"
module tlc_chk #(
  parameter LW = 12,
  parameter NC = 3
) (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata_r,
  input wire logic               reg_rvalid_r,
  input wire logic [NC-1:0]      smp_valid,
  input wire logic [NC-1:0]      alarm_hi_r,
  input wire logic [NC-1:0]      alarm_lo_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Read answer one cycle after the strobe, never without one
  AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid_r) else $error("read not answered");
  AST_RD_ONLY: assert property (!reg_rd |=> !reg_rvalid_r) else $error("answer without read");
  // A flag rises only three edges after a sample was taken
  AST_INT_RISE: assert property ($rose(alarm_hi_r[0]) || $rose(alarm_lo_r[0]) |-> $past(smp_valid[0], 3))
    else $error("internal flag without sample");
  AST_R1_RISE: assert property ($rose(alarm_hi_r[1]) || $rose(alarm_lo_r[1]) |-> $past(smp_valid[1], 3))
    else $error("remote one flag without sample");
  AST_R2_RISE: assert property ($rose(alarm_hi_r[2]) || $rose(alarm_lo_r[2]) |-> $past(smp_valid[2], 3))
    else $error("remote two flag without sample");
  // Internal and remote one status reads return the flags; remote two flags hold until read
  AST_INT_STAT: assert property (reg_rd && reg_addr == `TLC_REG_STAT_INT |=>
    reg_rdata_r[2:1] == {$past(alarm_hi_r[0]), $past(alarm_lo_r[0])}) else $error("internal status wrong");
  AST_R1_STAT: assert property (reg_rd && reg_addr == `TLC_REG_STAT_R1 |=>
    reg_rdata_r[2:1] == {$past(alarm_hi_r[1]), $past(alarm_lo_r[1])}) else $error("remote one status wrong");
  AST_R2_HOLD: assert property (!(reg_rd && reg_addr == `TLC_REG_STAT_R2) |=>
    alarm_hi_r[2] >= $past(alarm_hi_r[2]) && alarm_lo_r[2] >= $past(alarm_lo_r[2])) else $error("remote two flag lost");
  // Main scenarios
  COV_READ: cover property (reg_rd ##1 reg_rvalid_r);
  COV_INT_HI: cover property ($rose(alarm_hi_r[0]));
  COV_R2_LO: cover property ($rose(alarm_lo_r[2]));
endmodule // tlc_chk
bind tlc_top tlc_chk #(.LW(LW), .NC(NC)) tlc_chk_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .smp_valid(smp_valid),
  .alarm_hi_r(alarm_hi_r), .alarm_lo_r(alarm_lo_r));
`default_nettype wire

// file: testbench/tlc_host.sv
`timescale 1ns/10ps
`default_nettype none
module tlc_host (
  input  wire logic        clk_sys,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata_r,
  input  wire logic        reg_rvalid_r
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  // One-cycle write, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk_sys);
  endtask
  // One-cycle read, answer awaited a bounded count
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = '0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    for (int i = 0; i < 3 && !ok; i++)
    begin
      @(negedge clk_sys);
      ok = (reg_rvalid_r === 1'b1);
      d = reg_rdata_r;
    end
    @(posedge clk_sys);
  endtask
endmodule // tlc_host
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlc_defs.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  logic        clk_sys;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata_r;
  logic        reg_rvalid_r;
  logic [2:0]  smp_valid;
  logic [35:0] smp_data;
  logic [2:0]  alarm_hi_r;
  logic [2:0]  alarm_lo_r;
  logic [31:0] seed;
  logic [15:0] d;
  logic        ok;
  logic [11:0] smp[3][32];
  logic [11:0] hi_l;
  logic [11:0] lo_l;
  int          k;
  int          err_count;
  int          compares;
  tlc_top tlc_top_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .smp_valid(smp_valid),
    .smp_data(smp_data), .alarm_hi_r(alarm_hi_r), .alarm_lo_r(alarm_lo_r));
  tlc_host tlc_host_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));
  // 50 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Floor mean of the first 4<<m samples
  function automatic logic [11:0] mean(input int c, input int m);
    int s = 0;
    for (int i = 0; i < (4 << m); i++)
      s += $signed(smp[c][i]);
    return 12'(s >>> (m + 2));
  endfunction
  task automatic print_verdict();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] msk);
    tlc_host_i.rd(a, d, ok);
    if (!ok)
    begin
      err_count++;
      print_verdict();
    end
    `CHK("read data", e & msk, d & msk)
  endtask
  // Sample stream on all channels, then wait for the flags
  task automatic feed(input int n);
    for (int i = 0; i < n; i++)
    begin
      smp_valid <= 3'b111;
      smp_data <= {smp[2][i], smp[1][i], smp[0][i]};
      @(posedge clk_sys);
    end
    smp_valid <= 3'b000;
    smp_data <= ~smp_data;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Main sequence
  initial
  begin
    seed = 32'h4990_f610;
    err_count = 0;
    compares = 0;
    rstn = 1'b0;
    smp_valid = 3'b000;
    smp_data = '0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int r = 0; r < 6; r++)
      rdchk(8'(5 + r), r[0] ? 16'h0800 : 16'h07ff, 16'h0fff);
    rdchk(8'hff, 16'h0000, 16'hffff);
    tlc_host_i.wr(`TLC_REG_ENABLES, 16'h0007);
    rdchk(`TLC_REG_ENABLES, 16'h0007, 16'hffff);
    for (int m = 0; m < 4; m++)
    begin
      tlc_host_i.wr(`TLC_REG_AVG, {10'h000, m[1:0], m[1:0], m[1:0]});
      rdchk(`TLC_REG_AVG, {10'h000, m[1:0], m[1:0], m[1:0]}, 16'hffff);
      for (int c = 0; c < 3; c++)
      begin
        for (int i = 0; i < 32; i++)
          smp[c][i] = 12'($signed(rnd()) >>> 21);
        k = (c + m) % 3;
        hi_l = (k == 0) ? mean(c, m) - 12'h001 : mean(c, m);
        lo_l = (k == 1) ? mean(c, m) + 12'h001 : mean(c, m);
        tlc_host_i.wr(8'(5 + 2 * c), {4'ha, hi_l});
        tlc_host_i.wr(8'(6 + 2 * c), {4'h5, lo_l});
        rdchk(8'(5 + 2 * c), {4'h0, hi_l}, 16'h0fff);
        rdchk(8'(6 + 2 * c), {4'h0, lo_l}, 16'h0fff);
      end
      feed(4 << m);
      for (int c = 0; c < 3; c++)
      begin
        `CHK("alarm high", (c + m) % 3 == 0, alarm_hi_r[c])
        `CHK("alarm low", (c + m) % 3 == 1, alarm_lo_r[c])
      end
      @(posedge clk_sys);
      // Averaged results read back before the status reads
      for (int c = 0; c < 3; c++)
        rdchk(8'(11 + c), {4'h0, mean(c, m)}, 16'hffff);
      for (int c = 0; c < 3; c++)
        rdchk(8'(2 + c), {13'h0000, (c + m) % 3 == 0, (c + m) % 3 == 1, 1'b0}, 16'hffff);
      @(negedge clk_sys);
      `CHK("flags after read", 6'h00, {alarm_hi_r, alarm_lo_r})
      @(posedge clk_sys);
    end
    // Remote one disabled, upper limits at the signed minimum
    tlc_host_i.wr(`TLC_REG_ENABLES, 16'h0005);
    tlc_host_i.wr(`TLC_REG_AVG, 16'h0000);
    for (int c = 0; c < 3; c++)
      tlc_host_i.wr(8'(5 + 2 * c), 16'h0800);
    smp = '{default: '0};
    feed(4);
    `CHK("disabled channel", 3'b101, alarm_hi_r)
    // Mid-run reset brings flags, enables and limits back
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    `CHK("flags after reset", 6'h00, {alarm_hi_r, alarm_lo_r})
    rdchk(`TLC_REG_INT_HI, 16'h07ff, 16'hffff);
    rdchk(`TLC_REG_ENABLES, 16'h0000, 16'hffff);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
